/* inc/status_defines.svh */
// selector codes, field layout, reset values for status reporting
// assumes: included by bare name from the package and the rtl file
`ifndef STATUS_DEFINES_SVH
`define STATUS_DEFINES_SVH

// register selectors on the access port
`define SEL_OPER_BASE 5'h00
`define SEL_QUES_BASE 5'h05
`define PART_COND 5'h00
`define PART_RISE 5'h01
`define PART_FALL 5'h02
`define PART_EVENT 5'h03
`define PART_MASK 5'h04
`define SEL_STD_EVENT 5'h0a
`define SEL_STD_MASK 5'h0b
`define SEL_STB 5'h0c
`define SEL_SRQ_MASK 5'h0d
`define SEL_PP_MASK 5'h0e
`define SEL_SERIAL_POLL 5'h0f
`define SEL_IST 5'h10

// field layout
`define PART_W 16
`define STB_W 8
`define VALID_BITS 16'h7fff
`define STB_ERRQ_BIT 2
`define STB_QUES_BIT 3
`define STB_MAV_BIT 4
`define STB_ESB_BIT 5
`define STB_MSS_BIT 6
`define STB_OPER_BIT 7

// reset values
`define RISE_RST 16'h7fff
`define FALL_RST 16'h0000
`define MASK_RST 16'h0000
`define STB_MASK_RST 8'h00

`endif

/* inc/status_pkg.sv */
// types shared by the status reporting block and its bench
// assumes: status_defines.svh is on the include path
`default_nettype none
`include "status_defines.svh"

package status_pkg;
    // one register access: read or write strobe with selector
    typedef struct packed {
        logic rd;
        logic wr;
        logic [4:0] sel;
        logic [`PART_W-1:0] wdata;
    } acc_req_t;

    // answer to a read, one cycle after the strobe
    typedef struct packed {
        logic valid;
        logic [`PART_W-1:0] rdata;
    } acc_rsp_t;
endpackage
`default_nettype wire

/* rtl/status_report.sv */
// hierarchical status reporting: two five-part status registers,
// standard event register, status byte, service request and ist flag
// assumes: one 10 MHz core clock; the command parser drives acc_req
// on this clock; condition pins are asynchronous

`timescale 1ns/1ps
`default_nettype none
`include "status_defines.svh"

// What this block does
// - operation and questionable registers have five 16-bit parts
// - bit 15 of every part reads zero
// - condition follows hardware, read-only, never cleared
// - rising condition sets event if rise filter
// - falling condition sets event if fall filter
// - edge filters writable, readable, read harmless
// - event latches filtered edges until read
// - event read-only, reading clears it
// - summary is OR of event AND enable
// - enable part writable, readable, read harmless
// - summaries feed condition bits one level up
// - status byte gathers esb, operation, questionable summaries
// - status byte bit 6 summarises other bits
// - status byte returned by query or poll
// - service request mask bit 6 ignored
// - masked status byte rise raises service request
// - service request mask stored and read back
// - ist flag masked by parallel poll mask
// - message-available bit follows output buffer
// - standard event mask gates its summary
// - all status registers readable by controller
// - status byte bit 4 is message-available
// - ist is OR of byte AND mask, bit6 included
module status_report (
    input wire logic clk,
    input wire logic sys_rst,
    // operation register condition, from pins
    input wire logic [15:0] oper_cond_pin,
    // questionable register condition, from pins
    input wire logic [15:0] ques_cond_pin,
    // standard event set pulses, same clock
    input wire logic [15:0] std_event_set,
    // error queue holds at least one entry
    input wire logic error_queue_nonempty,
    // output buffer holds readable data
    input wire logic message_available_bit,
    input wire status_pkg::acc_req_t acc_req,
    output status_pkg::acc_rsp_t acc_rsp,
    output logic service_request,
    output logic individual_status
);

    // both five-part registers share one generate body
    localparam int NREG = 2;

    // pins packed by register number: 0 operation, 1 questionable
    logic [NREG-1:0][15:0] pin_w;
    assign pin_w = {ques_cond_pin, oper_cond_pin};

    // per-register storage
    logic [NREG-1:0][15:0] sync1_ff; // first synchroniser stage
    logic [NREG-1:0][15:0] cond_ff; // condition part
    logic [NREG-1:0][15:0] prev_ff; // condition one cycle ago
    logic [NREG-1:0][15:0] rise_ff; // rise filter part
    logic [NREG-1:0][15:0] fall_ff; // fall filter part
    logic [NREG-1:0][15:0] event_ff; // event latch part
    logic [NREG-1:0][15:0] mask_ff; // event mask part
    logic [NREG-1:0][15:0] nxt_event; // next event latch
    logic [NREG-1:0] sum_w; // summary bit per register

    // per-register read data, chosen by part
    logic [NREG-1:0][15:0] part_rd_w;
    logic [NREG-1:0] part_hit_w;

    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : g_reg
            // selector base of this register
            localparam logic [4:0] BASE = (g == 0) ?
                `SEL_OPER_BASE : `SEL_QUES_BASE;

            // selector decode for each part, plus write and clearing strobes
            wire logic hit_rise = acc_req.sel == BASE + `PART_RISE;
            wire logic hit_fall = acc_req.sel == BASE + `PART_FALL;
            wire logic hit_event = acc_req.sel == BASE + `PART_EVENT;
            wire logic hit_mask = acc_req.sel == BASE + `PART_MASK;
            wire logic hit_cond = acc_req.sel == BASE + `PART_COND;
            wire logic wr_rise = acc_req.wr && hit_rise;
            wire logic wr_fall = acc_req.wr && hit_fall;
            wire logic wr_mask = acc_req.wr && hit_mask;
            wire logic rd_event = acc_req.rd && hit_event;

            // filtered edges of the sampled condition
            wire logic [15:0] up_w = cond_ff[g] & ~prev_ff[g];
            wire logic [15:0] dn_w = ~cond_ff[g] & prev_ff[g];
            wire logic [15:0] rise_ev = up_w & rise_ff[g];
            wire logic [15:0] fall_ev = dn_w & fall_ff[g];

            // read clears first, then new edges set again
            assign nxt_event[g] = (rd_event ? 16'h0000 : event_ff[g])
                | rise_ev | fall_ev;

            // masked OR gives the summary
            assign sum_w[g] = |(event_ff[g] & mask_ff[g]);

            // part readback mux for this register
            assign part_hit_w[g] = hit_rise | hit_fall | hit_event
                | hit_mask | hit_cond;
            assign part_rd_w[g] = hit_cond ? cond_ff[g] :
                hit_rise ? rise_ff[g] :
                hit_fall ? fall_ff[g] :
                hit_event ? event_ff[g] :
                hit_mask ? mask_ff[g] : 16'h0000;

            // condition path: two stages, then previous copy
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    sync1_ff[g] <= 16'h0000;
                    cond_ff[g] <= 16'h0000;
                    prev_ff[g] <= 16'h0000;
                end else begin
                    // raw pins go straight into the first stage;
                    // bit 15 is dropped on the way into the second
                    sync1_ff[g] <= pin_w[g];
                    cond_ff[g] <= sync1_ff[g] & `VALID_BITS;
                    prev_ff[g] <= cond_ff[g];
                end
            end

            // user parts: filters and mask take writes only
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    rise_ff[g] <= `RISE_RST;
                    fall_ff[g] <= `FALL_RST;
                    mask_ff[g] <= `MASK_RST;
                end else begin
                    if (wr_rise) begin
                        rise_ff[g] <= acc_req.wdata & `VALID_BITS;
                    end
                    if (wr_fall) begin
                        fall_ff[g] <= acc_req.wdata & `VALID_BITS;
                    end
                    if (wr_mask) begin
                        mask_ff[g] <= acc_req.wdata & `VALID_BITS;
                    end
                end
            end

            // event latch, sticky until read
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    event_ff[g] <= 16'h0000;
                end else begin
                    event_ff[g] <= nxt_event[g];
                end
            end
        end
    endgenerate

    // standard event register: event latch plus its mask only;
    // its events arrive as pulses, so no edge filter is needed
    logic [15:0] std_event_ff; // standard_event_register
    logic [15:0] std_mask_ff; // standard_event_mask
    logic [15:0] nxt_std_event;
    wire logic hit_std_event = acc_req.sel == `SEL_STD_EVENT;
    wire logic hit_std_mask = acc_req.sel == `SEL_STD_MASK;
    wire logic rd_std_event = acc_req.rd && hit_std_event;
    wire logic wr_std_mask = acc_req.wr && hit_std_mask;

    // read clear loses to a pulse in the same cycle
    assign nxt_std_event = (rd_std_event ? 16'h0000 : std_event_ff)
        | (std_event_set & `VALID_BITS);

    // summary of the standard event register
    wire logic esb_w = |(std_event_ff & std_mask_ff);

    // standard event latch and its mask
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            std_event_ff <= 16'h0000;
            std_mask_ff <= `MASK_RST;
        end else begin
            std_event_ff <= nxt_std_event;
            if (wr_std_mask) begin
                std_mask_ff <= acc_req.wdata & `VALID_BITS;
            end
        end
    end

    // top level masks
    logic [7:0] srq_mask_ff; // service_request_mask
    logic [7:0] pp_mask_ff; // parallel_poll_mask
    wire logic hit_srq_mask = acc_req.sel == `SEL_SRQ_MASK;
    wire logic hit_pp_mask = acc_req.sel == `SEL_PP_MASK;
    wire logic hit_stb = acc_req.sel == `SEL_STB;
    wire logic hit_poll = acc_req.sel == `SEL_SERIAL_POLL;
    wire logic hit_ist = acc_req.sel == `SEL_IST;
    wire logic rd_poll = acc_req.rd && hit_poll;

    // status byte without its summary bit; bits 0 and 1 unused
    logic [7:0] stb_low_w;
    assign stb_low_w = {
        sum_w[0], // operation summary
        1'b0, // summary slot filled below
        esb_w, // standard event summary
        message_available_bit,
        sum_w[1], // questionable summary
        error_queue_nonempty,
        2'b00
    };

    // mask with bit 6 forced out, whatever was written
    logic [7:0] srq_eff_w;
    assign srq_eff_w = srq_mask_ff & ~(8'h01 << `STB_MSS_BIT);

    // bit 6 summarises the other masked bits
    wire logic mss_w = |(stb_low_w & srq_eff_w);

    // complete status byte as the query returns it
    logic [7:0] top_status_byte;
    assign top_status_byte = stb_low_w
        | ({7'h00, mss_w} << `STB_MSS_BIT);

    // status byte seen last cycle, for rise detection
    logic [7:0] stb_prev_ff;

    // any enabled bit that rose this cycle asks for service
    wire logic srq_set_w =
        |(top_status_byte & ~stb_prev_ff & srq_eff_w);

    // request line: held until a serial poll reads it;
    // a new rise in the poll cycle keeps it up
    logic srq_ff;
    logic nxt_srq;
    assign nxt_srq = srq_set_w | (srq_ff & ~rd_poll);

    // the poll byte carries the pending request in bit 6
    logic [7:0] poll_byte_w;
    assign poll_byte_w = (top_status_byte
        & ~(8'h01 << `STB_MSS_BIT))
        | ({7'h00, srq_ff} << `STB_MSS_BIT);

    // ist: whole byte against its mask, bit 6 counts here
    wire logic ist_w = |(top_status_byte & pp_mask_ff);

    // top level masks, written from the access port
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            srq_mask_ff <= `STB_MASK_RST;
            pp_mask_ff <= `STB_MASK_RST;
        end else begin
            if (acc_req.wr && hit_srq_mask) begin
                srq_mask_ff <= acc_req.wdata[7:0];
            end
            if (acc_req.wr && hit_pp_mask) begin
                pp_mask_ff <= acc_req.wdata[7:0];
            end
        end
    end

    // request and ist flip-flops drive the outputs
    logic ist_ff;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stb_prev_ff <= 8'h00;
            srq_ff <= 1'b0;
            ist_ff <= 1'b0;
        end else begin
            stb_prev_ff <= top_status_byte;
            srq_ff <= nxt_srq;
            ist_ff <= ist_w;
        end
    end

    assign service_request = srq_ff;
    assign individual_status = ist_ff;

    // read mux for the part, standard event and top level registers;
    // top level masks and bytes read in the low bits, rest zero
    logic [15:0] rd_mux_w;
    assign rd_mux_w = part_hit_w[0] ? part_rd_w[0] :
        part_hit_w[1] ? part_rd_w[1] :
        hit_std_event ? std_event_ff :
        hit_std_mask ? std_mask_ff :
        hit_stb ? {8'h00, top_status_byte} :
        hit_poll ? {8'h00, poll_byte_w} :
        hit_srq_mask ? {8'h00, srq_mask_ff} :
        hit_pp_mask ? {8'h00, pp_mask_ff} :
        hit_ist ? {15'h0000, ist_ff} :
        16'h0000;

    // registered answer: one cycle after the read strobe;
    // an unknown selector reads zero, never stalls
    logic rsp_valid_ff;
    logic [15:0] rsp_data_ff;
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rsp_valid_ff <= 1'b0;
            rsp_data_ff <= 16'h0000;
        end else begin
            rsp_valid_ff <= acc_req.rd;
            if (acc_req.rd) begin
                rsp_data_ff <= rd_mux_w & `VALID_BITS;
            end
        end
    end

    assign acc_rsp.valid = rsp_valid_ff;
    assign acc_rsp.rdata = rsp_data_ff;

endmodule

`default_nettype wire

/* tb/status_report_chk.sv */
// concurrent checks on the status reporting block's top ports
// assumes: bound from the bench top; one clock, sync reset high
`timescale 1ns/1ps
`default_nettype none
`include "status_defines.svh"
module status_report_chk (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic [15:0] oper_cond_pin,
    input wire logic [15:0] ques_cond_pin,
    input wire logic [15:0] std_event_set,
    input wire logic error_queue_nonempty,
    input wire logic message_available_bit,
    input wire status_pkg::acc_req_t acc_req,
    input wire status_pkg::acc_rsp_t acc_rsp,
    input wire logic service_request,
    input wire logic individual_status
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    // read strobes decoded per selector of interest
    wire logic rd_stb = acc_req.rd && acc_req.sel == `SEL_STB;
    wire logic rd_poll = acc_req.rd && acc_req.sel == `SEL_SERIAL_POLL;
    wire logic rd_ist = acc_req.rd && acc_req.sel == `SEL_IST;
    wire logic rd_esr = acc_req.rd && acc_req.sel == `SEL_STD_EVENT;
    wire logic rd_rise = acc_req.rd && acc_req.sel == `PART_RISE;
    bit15_zero_a: assert property (acc_rsp.rdata[15] == 1'b0)
        else $error("read data bit 15 set");
    answer_valid_a: assert property (acc_rsp.valid == $past(acc_req.rd))
        else $error("read answer not one cycle after strobe");
    ist_read_a: assert property (rd_ist |=>
        acc_rsp.rdata == {15'h0000, $past(individual_status)})
        else $error("ist read differs from ist output");
    poll_bit_a: assert property (rd_poll |=>
        acc_rsp.rdata[6] == $past(service_request))
        else $error("poll bit 6 differs from pending request");
    srq_hold_a: assert property (service_request && !rd_poll |=>
        service_request)
        else $error("service request dropped without poll");
    esr_clear_a: assert property (rd_esr && std_event_set == 16'h0000
        ##1 rd_esr |=> acc_rsp.rdata == 16'h0000)
        else $error("event read did not clear");
    mav_byte_a: assert property (rd_stb && $stable(message_available_bit)
        |=> acc_rsp.rdata[4] == $past(message_available_bit))
        else $error("byte bit 4 differs from output buffer flag");
    filter_read_a: assert property (rd_rise && !acc_req.wr ##1 rd_rise
        |=> $stable(acc_rsp.rdata))
        else $error("filter changed by reading");
    // main scenarios reached
    cover property ($rose(service_request));
    cover property (rd_poll && service_request);
    cover property ($rose(individual_status));
endmodule
`default_nettype wire

/* tb/status_controller.sv */
// bus controller model: register writes, reads and serial polls
// assumes: calls start 1 ns after a rising clk edge
`timescale 1ns/1ps
`default_nettype none
module status_controller (
    input wire logic clk,
    output var status_pkg::acc_req_t acc_req,
    input wire status_pkg::acc_rsp_t acc_rsp
);
    // bus idle from time zero
    initial acc_req = '0;
    // one write strobe, then an idle edge so strobes never merge
    task automatic write(input logic [4:0] s, input logic [15:0] v);
        acc_req.wr = 1'b1;
        acc_req.sel = s;
        acc_req.wdata = v;
        @(posedge clk);
        #1;
        acc_req.wr = 1'b0;
        acc_req.wdata = ~v; // stale data must not look valid
        @(posedge clk);
        #1;
    endtask
    // one or two back-to-back reads; no answer gives unknown data
    task automatic read(input logic [4:0] s, input logic two,
            output logic [15:0] d0, output logic [15:0] d1);
        acc_req.rd = 1'b1;
        acc_req.sel = s;
        @(posedge clk);
        #1;
        d0 = acc_rsp.valid ? acc_rsp.rdata : 16'hxxxx;
        acc_req.rd = two;
        @(posedge clk);
        #1;
        d1 = acc_rsp.valid ? acc_rsp.rdata : 16'hxxxx;
        acc_req.rd = 1'b0;
        @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

/* tb/test_hierarchical_status_reporting.sv */
// self-checking bench for the status reporting block
// assumes: controller model owns the access port; checker bound below
`timescale 1ns/1ps
`default_nettype none
`include "status_defines.svh"
module test_hierarchical_status_reporting;
    localparam logic [4:0] op = `SEL_OPER_BASE; // operation register
    localparam logic [4:0] qu = `SEL_QUES_BASE; // questionable register
    logic clk;
    logic sys_rst;
    logic [15:0] oper_cond_pin;
    logic [15:0] ques_cond_pin;
    logic [15:0] std_event_set;
    logic error_queue_nonempty;
    logic message_available_bit;
    status_pkg::acc_req_t acc_req;
    status_pkg::acc_rsp_t acc_rsp;
    logic service_request;
    logic individual_status;
    int num_errors = 0;
    int check_count = 0;
    logic [15:0] d0;
    logic [15:0] d1;
    status_report DUT (.clk, .sys_rst, .oper_cond_pin, .ques_cond_pin,
        .std_event_set, .error_queue_nonempty, .message_available_bit,
        .acc_req, .acc_rsp, .service_request, .individual_status);
    status_controller ctl (.clk, .acc_req, .acc_rsp);
    // 100 ns core clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    task automatic check(input string what, input logic [15:0] exp,
            input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic check1(input string what, input logic exp,
            input logic got);
        check(what, {15'h0000, exp}, {15'h0000, got});
    endtask
    task automatic rd(input logic [4:0] s, input logic [15:0] exp,
            input string what);
        ctl.read(s, 1'b0, d0, d1);
        check(what, exp, d0);
    endtask
    // pin sync plus edge, latch and request stages fit in five edges
    task automatic settle;
        repeat (5) @(posedge clk);
        #1;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // hang guard
    initial begin
        repeat (5000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
    initial begin
        sys_rst = 1'b1;
        oper_cond_pin = 16'h0000;
        ques_cond_pin = 16'h0000;
        std_event_set = 16'h0000;
        error_queue_nonempty = 1'b0;
        message_available_bit = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        rd(op + `PART_RISE, `RISE_RST, "oper rise");
        rd(qu + `PART_FALL, `FALL_RST, "ques fall");
        rd(qu + `PART_MASK, `MASK_RST, "ques mask");
        ctl.write(op + `PART_RISE, 16'hffff);
        ctl.read(op + `PART_RISE, 1'b1, d0, d1);
        check("rise first", 16'h7fff, d0);
        check("rise again", 16'h7fff, d1);
        ctl.write(op + `PART_FALL, 16'h0001);
        ctl.write(op + `PART_MASK, 16'h0001);
        rd(op + `PART_MASK, 16'h0001, "oper mask");
        ctl.write(`SEL_SRQ_MASK, 16'h0080);
        $display("test registers done");
        // operation edges up through the status byte
        oper_cond_pin = 16'h8001;
        settle();
        rd(op + `PART_COND, 16'h0001, "cond");
        ctl.write(op + `PART_COND, 16'h0000);
        rd(op + `PART_COND, 16'h0001, "cond kept");
        check1("srq up", 1'b1, service_request);
        rd(`SEL_STB, 16'h00c0, "byte");
        rd(`SEL_SERIAL_POLL, 16'h00c0, "poll");
        check1("srq polled", 1'b0, service_request);
        ctl.read(op + `PART_EVENT, 1'b1, d0, d1);
        check("event", 16'h0001, d0);
        check("event cleared", 16'h0000, d1);
        rd(`SEL_STB, 16'h0000, "byte idle");
        oper_cond_pin = 16'h0000;
        settle();
        rd(op + `PART_EVENT, 16'h0001, "fall event");
        ctl.write(op + `PART_RISE, 16'h0000);
        ctl.write(op + `PART_FALL, 16'h0000);
        oper_cond_pin = 16'h0001;
        settle();
        oper_cond_pin = 16'h0000;
        settle();
        rd(op + `PART_EVENT, 16'h0000, "filtered");
        rd(`SEL_SERIAL_POLL, 16'h0040, "poll pending");
        $display("test operation done");
        // questionable, standard event, buffer and error flags
        ctl.write(qu + `PART_MASK, 16'h0004);
        ques_cond_pin = 16'h0004;
        ctl.write(`SEL_STD_MASK, 16'h0001);
        std_event_set = 16'h0001;
        @(posedge clk);
        #1;
        std_event_set = 16'h0000;
        settle();
        rd(`SEL_STB, 16'h0028, "byte ques std");
        ctl.read(`SEL_STD_EVENT, 1'b1, d0, d1);
        check("std event", 16'h0001, d0);
        check("std cleared", 16'h0000, d1);
        error_queue_nonempty = 1'b1;
        message_available_bit = 1'b1;
        settle();
        rd(`SEL_STB, 16'h001c, "byte flags");
        check1("srq masked", 1'b0, service_request);
        message_available_bit = 1'b0;
        ctl.write(`SEL_SRQ_MASK, 16'h0040);
        message_available_bit = 1'b1;
        settle();
        check1("srq bit6", 1'b0, service_request);
        rd(`SEL_SRQ_MASK, 16'h0040, "srq mask");
        message_available_bit = 1'b0;
        ctl.write(`SEL_SRQ_MASK, 16'h0010);
        message_available_bit = 1'b1;
        settle();
        check1("srq mav", 1'b1, service_request);
        rd(`SEL_STB, 16'h005c, "byte mss");
        ctl.write(`SEL_PP_MASK, 16'h0040);
        settle();
        rd(`SEL_IST, 16'h0001, "ist");
        check1("ist out", 1'b1, individual_status);
        ctl.write(`SEL_PP_MASK, 16'h0003);
        settle();
        rd(`SEL_IST, 16'h0000, "ist low");
        rd(`SEL_SERIAL_POLL, 16'h005c, "poll last");
        check1("srq end", 1'b0, service_request);
        // remaining readbacks; the questionable read clears its sum
        rd(qu + `PART_EVENT, 16'h0004, "ques event");
        rd(`SEL_STB, 16'h0054, "byte no ques");
        rd(`SEL_PP_MASK, 16'h0003, "pp mask");
        rd(`SEL_STD_MASK, 16'h0001, "std mask");
        $display("test summary done");
        give_verdict();
    end
endmodule
bind status_report status_report_chk chk (.clk, .sys_rst, .oper_cond_pin,
    .ques_cond_pin, .std_event_set, .error_queue_nonempty,
    .message_available_bit, .acc_req, .acc_rsp, .service_request,
    .individual_status);
`default_nettype wire
